// *** jts_pkg.sv ***
// Purpose: Constants and types for the test access port with serial-wire switch
// Assumes: 200 MHz system clock samples the test clock pin
// Notes: Instruction codes follow the 4-bit instruction register
package jts_pkg;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET,
    RUN_TEST_IDLE,
    SELECT_DR,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SELECT_IR,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } jts_state_e;

  typedef enum logic [2:0] {
    SW_IDLE,
    SW_RTI,
    SW_SDR,
    SW_SIR,
    SW_CIR,
    SW_E1,
    SW_UIR
  } jts_swpre_e;

  localparam int          IR_W        = 4;
  localparam int          DAP_W       = 35;
  localparam int          ACK_W       = 3;
  localparam int          DATA_W      = 32;
  localparam int          PIN_N       = 5;
  localparam int          TMS_RESET_N = 5;
  localparam logic [3:0]  IR_ABORT    = 4'h8;
  localparam logic [3:0]  IR_DPACC    = 4'hA;
  localparam logic [3:0]  IR_APACC    = 4'hB;
  localparam logic [3:0]  IR_IDCODE   = 4'hE;
  localparam logic [3:0]  IR_BYPASS   = 4'hF;
  localparam logic [3:0]  IR_CAPTURE  = 4'h1;
  localparam logic [4:0]  PIN_DEFAULT = 5'h1F;
  localparam logic [31:0] ID_DEFAULT  = 32'h10000001; // Arbitrary identity value
  localparam int          IR_PASSES   = 2;

endpackage

// *** jts_sync.sv ***
// Purpose: Two-flop synchroniser for one pin level
// Assumes: Input is asynchronous to clk_in
// Notes: Only the second stage is read outside
module jts_sync (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Level
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_r;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      meta_r <= 1'b1;
      q_out  <= 1'b1;
    end
    else
    begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule

// *** jts_tap.sv ***
// Purpose: Test access port controller with serial-wire switching detection
// Assumes: Test pins are sampled by the 200 MHz clock; pins idle high by pull-ups
// Notes on behaviour
// - Power-on reset or a low test reset pin forces the state machine to Test-Logic-Reset.
// - Capture states load the selected chain in parallel with its sampled information.
// - Shift states move chain contents out on data-out while data-in fills it.
// - Update states copy the shifted chain into its parallel load register.
// - After reset the five test pins have pull-up enable and alternate select set.
// - Clearing alternate select bit 0 sets GPIO mode, stops the state machine and drops the data-out enable.
// - Capture-DR on debug access chains returns the last result with a 3-bit ack.
// - Two instruction loads with no shift enable serial-wire and disable JTAG.
// - Five test clocks with mode-select high reach Test-Logic-Reset from any state.
// - Entering Test-Logic-Reset loads the identification instruction.
// - Mode-select is sampled on the test clock rising edge.
module jts_tap (
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  // Test pins
  input  wire logic                    tck_in,
  input  wire logic                    tms_in,
  input  wire logic                    tdi_in,
  input  wire logic                    test_reset_n_in,
  output logic                         tdo_out,
  output logic                         tdo_oe_out,
  // Pad configuration from software
  input  wire logic [4:0]              alt_function_select_in,
  input  wire logic [4:0]              pull_up_enable_in,
  input  wire logic                    pad_cfg_wr_in,
  output logic [4:0]                   alt_function_select_out,
  output logic [4:0]                   pull_up_enable_out,
  output logic                         gpio_mode_out,
  // Debug access port side
  input  wire logic [31:0]             dap_rdata_in,
  input  wire logic [2:0]              dap_ack_in,
  output logic [3:0]                   ir_out,
  output logic [34:0]                  dap_wdata_out,
  output logic                         dap_update_out,
  output logic                         sw_enable_out
);
  logic tck_s, tms_s, tdi_s, trst_s;
  logic tck_q_r;
  jts_pkg::jts_state_e state_r, state_nxt;
  jts_pkg::jts_swpre_e sw_r, sw_nxt;
  logic [3:0]  ir_sh_r;
  logic [34:0] dr_sh_r;
  logic [1:0]  pass_r;

  jts_sync u_tck  (.clk_in(clk_in), .rst_n_in(rst_n_in), .d_in(tck_in), .q_out(tck_s));
  jts_sync u_tms  (.clk_in(clk_in), .rst_n_in(rst_n_in), .d_in(tms_in), .q_out(tms_s));
  jts_sync u_tdi  (.clk_in(clk_in), .rst_n_in(rst_n_in), .d_in(tdi_in), .q_out(tdi_s));
  jts_sync u_trst (.clk_in(clk_in), .rst_n_in(rst_n_in), .d_in(test_reset_n_in),
                   .q_out(trst_s));

  wire rise_w   = tck_s & ~tck_q_r;
  wire fall_w   = ~tck_s & tck_q_r;
  wire trst_w   = ~trst_s;
  wire jtag_on  = alt_function_select_out[0] & ~sw_enable_out;
  wire step_w   = rise_w & jtag_on;
  wire dap_sel  = (ir_out == jts_pkg::IR_DPACC) | (ir_out == jts_pkg::IR_APACC)
                | (ir_out == jts_pkg::IR_ABORT);
  wire id_sel   = (ir_out == jts_pkg::IR_IDCODE);
  wire shift_on = (state_r == jts_pkg::SHIFT_DR) | (state_r == jts_pkg::SHIFT_IR);
  wire dr_bit   = dap_sel ? dr_sh_r[0] : (id_sel ? dr_sh_r[0] : dr_sh_r[0]);
  wire tdo_bit  = (state_r == jts_pkg::SHIFT_IR) ? ir_sh_r[0] : dr_bit;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      jts_pkg::TEST_LOGIC_RESET:
        state_nxt = tms_s ? jts_pkg::TEST_LOGIC_RESET : jts_pkg::RUN_TEST_IDLE;
      jts_pkg::RUN_TEST_IDLE:
        state_nxt = tms_s ? jts_pkg::SELECT_DR : jts_pkg::RUN_TEST_IDLE;
      jts_pkg::SELECT_DR:
        state_nxt = tms_s ? jts_pkg::SELECT_IR : jts_pkg::CAPTURE_DR;
      jts_pkg::CAPTURE_DR:
        state_nxt = tms_s ? jts_pkg::EXIT1_DR : jts_pkg::SHIFT_DR;
      jts_pkg::SHIFT_DR:
        state_nxt = tms_s ? jts_pkg::EXIT1_DR : jts_pkg::SHIFT_DR;
      jts_pkg::EXIT1_DR:
        state_nxt = tms_s ? jts_pkg::UPDATE_DR : jts_pkg::PAUSE_DR;
      jts_pkg::PAUSE_DR:
        state_nxt = tms_s ? jts_pkg::EXIT2_DR : jts_pkg::PAUSE_DR;
      jts_pkg::EXIT2_DR:
        state_nxt = tms_s ? jts_pkg::UPDATE_DR : jts_pkg::SHIFT_DR;
      jts_pkg::UPDATE_DR:
        state_nxt = tms_s ? jts_pkg::SELECT_DR : jts_pkg::RUN_TEST_IDLE;
      jts_pkg::SELECT_IR:
        state_nxt = tms_s ? jts_pkg::TEST_LOGIC_RESET : jts_pkg::CAPTURE_IR;
      jts_pkg::CAPTURE_IR:
        state_nxt = tms_s ? jts_pkg::EXIT1_IR : jts_pkg::SHIFT_IR;
      jts_pkg::SHIFT_IR:
        state_nxt = tms_s ? jts_pkg::EXIT1_IR : jts_pkg::SHIFT_IR;
      jts_pkg::EXIT1_IR:
        state_nxt = tms_s ? jts_pkg::UPDATE_IR : jts_pkg::PAUSE_IR;
      jts_pkg::PAUSE_IR:
        state_nxt = tms_s ? jts_pkg::EXIT2_IR : jts_pkg::PAUSE_IR;
      jts_pkg::EXIT2_IR:
        state_nxt = tms_s ? jts_pkg::UPDATE_IR : jts_pkg::SHIFT_IR;
      jts_pkg::UPDATE_IR:
        state_nxt = tms_s ? jts_pkg::SELECT_DR : jts_pkg::RUN_TEST_IDLE;
      default:
        state_nxt = jts_pkg::TEST_LOGIC_RESET;
    endcase
  end

  // Preamble tracker: walk of the instruction path without shifting
  always_comb
  begin
    sw_nxt = jts_pkg::SW_IDLE;
    case (sw_r)
      jts_pkg::SW_IDLE:
        sw_nxt = (state_r == jts_pkg::TEST_LOGIC_RESET && state_nxt == jts_pkg::RUN_TEST_IDLE)
               ? jts_pkg::SW_SDR : jts_pkg::SW_IDLE;
      jts_pkg::SW_RTI:
        sw_nxt = (state_nxt == jts_pkg::RUN_TEST_IDLE) ? jts_pkg::SW_SDR : jts_pkg::SW_IDLE;
      jts_pkg::SW_SDR:
        sw_nxt = (state_nxt == jts_pkg::SELECT_DR) ? jts_pkg::SW_SIR : jts_pkg::SW_IDLE;
      jts_pkg::SW_SIR:
        sw_nxt = (state_nxt == jts_pkg::SELECT_IR) ? jts_pkg::SW_CIR : jts_pkg::SW_IDLE;
      jts_pkg::SW_CIR:
        sw_nxt = (state_nxt == jts_pkg::CAPTURE_IR) ? jts_pkg::SW_E1 : jts_pkg::SW_IDLE;
      jts_pkg::SW_E1:
        sw_nxt = (state_nxt == jts_pkg::EXIT1_IR) ? jts_pkg::SW_UIR : jts_pkg::SW_IDLE;
      jts_pkg::SW_UIR:
        sw_nxt = (state_nxt == jts_pkg::UPDATE_IR) ? jts_pkg::SW_RTI : jts_pkg::SW_IDLE;
      default:
        sw_nxt = jts_pkg::SW_IDLE;
    endcase
  end

  wire pass_done = step_w & (sw_r == jts_pkg::SW_UIR) & (state_nxt == jts_pkg::UPDATE_IR);

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      tck_q_r <= 1'b1;
    else
      tck_q_r <= tck_s;
  end

  // State register and chains
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || trst_w)
    begin
      state_r        <= jts_pkg::TEST_LOGIC_RESET;
      ir_out         <= jts_pkg::IR_IDCODE;
      sw_r           <= jts_pkg::SW_IDLE;
      pass_r         <= 2'h0;
      dap_update_out <= 1'b0;
    end
    else
    begin
      dap_update_out <= 1'b0;
      if (step_w)
      begin
        state_r <= state_nxt;
        sw_r    <= sw_nxt;
        if (sw_nxt == jts_pkg::SW_IDLE)
          pass_r <= 2'h0;
        else if (pass_done && pass_r < 2'(jts_pkg::IR_PASSES))
          pass_r <= pass_r + 2'h1;
        case (state_r)
          jts_pkg::CAPTURE_IR:
            ir_sh_r <= jts_pkg::IR_CAPTURE;
          jts_pkg::SHIFT_IR:
            ir_sh_r <= {tdi_s, ir_sh_r[3:1]};
          jts_pkg::UPDATE_IR:
            ir_out <= ir_sh_r;
          jts_pkg::CAPTURE_DR:
          begin
            if (dap_sel)
              dr_sh_r <= {dap_rdata_in, dap_ack_in};
            else if (id_sel)
              dr_sh_r <= {3'h0, jts_pkg::ID_DEFAULT};
            else
              dr_sh_r <= 35'h0;
          end
          jts_pkg::SHIFT_DR:
          begin
            if (dap_sel)
              dr_sh_r <= {tdi_s, dr_sh_r[34:1]};
            else if (id_sel)
              dr_sh_r <= {3'h0, tdi_s, dr_sh_r[31:1]};
            else
              dr_sh_r <= {34'h0, tdi_s};
          end
          jts_pkg::UPDATE_DR:
          begin
            if (dap_sel)
            begin
              dap_wdata_out  <= dr_sh_r;
              dap_update_out <= 1'b1;
            end
          end
          default:
          begin
          end
        endcase
        if (state_nxt == jts_pkg::TEST_LOGIC_RESET)
          ir_out <= jts_pkg::IR_IDCODE;
      end
    end
  end

  // Serial-wire switch, sticky until reset
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || trst_w)
      sw_enable_out <= 1'b0;
    else if (pass_done && pass_r == 2'(jts_pkg::IR_PASSES - 1))
      sw_enable_out <= 1'b1;
  end

  // Data-out changes on the falling test clock edge
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      tdo_out    <= 1'b1;
      tdo_oe_out <= 1'b0;
    end
    else
    begin
      if (fall_w)
        tdo_out <= tdo_bit;
      if (!jtag_on || fall_w)
        tdo_oe_out <= shift_on & jtag_on;
    end
  end

  // Pad configuration
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      alt_function_select_out <= jts_pkg::PIN_DEFAULT;
      pull_up_enable_out      <= jts_pkg::PIN_DEFAULT;
    end
    else if (pad_cfg_wr_in)
    begin
      alt_function_select_out <= alt_function_select_in;
      pull_up_enable_out      <= pull_up_enable_in;
    end
  end
  assign gpio_mode_out = ~alt_function_select_out[0];

  property p_trst;
    @(posedge clk_in) disable iff (!rst_n_in) trst_w |=> state_r == jts_pkg::TEST_LOGIC_RESET;
  endproperty
  a_trst: assert property (p_trst) else $error("trst");
  property p_ir_reset;
    @(posedge clk_in) disable iff (!rst_n_in) trst_w |=> ir_out == jts_pkg::IR_IDCODE;
  endproperty
  a_ir_reset: assert property (p_ir_reset) else $error("ir reset");
  property p_upd;
    @(posedge clk_in) disable iff (!rst_n_in || trst_w)
      step_w && state_r == jts_pkg::UPDATE_IR |=> ir_out == $past(ir_sh_r);
  endproperty
  a_upd: assert property (p_upd) else $error("ir update");
  property p_hold;
    @(posedge clk_in) disable iff (!rst_n_in || trst_w) !step_w |=> state_r == $past(state_r);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved");
  property p_tlr;
    @(posedge clk_in) disable iff (!rst_n_in || trst_w) step_w && tms_s
      && state_r == jts_pkg::SELECT_IR |=> state_r == jts_pkg::TEST_LOGIC_RESET;
  endproperty
  a_tlr: assert property (p_tlr) else $error("select ir");
  property p_cap;
    @(posedge clk_in) disable iff (!rst_n_in || trst_w) step_w && dap_sel
      && state_r == jts_pkg::CAPTURE_DR |=> dr_sh_r[2:0] == $past(dap_ack_in);
  endproperty
  a_cap: assert property (p_cap) else $error("ack capture");
  property p_pad;
    @(posedge clk_in) !rst_n_in |=> alt_function_select_out == jts_pkg::PIN_DEFAULT;
  endproperty
  a_pad: assert property (p_pad) else $error("pad");
  property p_gpio;
    @(posedge clk_in) disable iff (!rst_n_in)
      gpio_mode_out |-> !tdo_oe_out || !$past(gpio_mode_out);
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio");
  c_sw: cover property (@(posedge clk_in) $rose(sw_enable_out));
  c_dap: cover property (@(posedge clk_in) dap_update_out);
  c_shift: cover property (@(posedge clk_in) state_r == jts_pkg::SHIFT_IR);
endmodule

// *** jts_probe.sv ***
// Purpose: Behavioural probe driving the test pins
// Assumes: Test clock of 125 ns, stopped low between frames
// Notes: Unused data-in rests at its pull-up level
module jts_probe (
  // Test pins
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out,
  output logic      test_reset_n_out,
  input  wire logic tdo_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
    test_reset_n_out = 1'b1;
  end

  // Ack polling skipped: system clock runs 25x the test clock
  task automatic bit_step(input logic tms, input logic tdi, output logic tdo);
    tms_out = tms;
    tdi_out = tdi;
    #62;
    tdo = tdo_in;
    tck_out = 1'b1;
    #62.5;
    tck_out = 1'b0;
    #0.5;
  endtask

  task automatic tms_walk(input logic [15:0] seq, input int n);
    logic d;
    for (int i = 0; i < n; i++)
      bit_step(seq[i], 1'b1, d);
  endtask

  // LSB first, leaves shift on the last bit
  task automatic scan(input logic [63:0] din, input int n, output logic [63:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++)
      bit_step(i == n - 1, din[i], dout[i]);
    tdi_out = 1'b1;
  endtask

  task automatic pin_reset(input logic lvl);
    test_reset_n_out = lvl;
  endtask
endmodule

// *** testbench.sv ***
// Purpose: Self-checking bench for the test access port
// Assumes: Probe model drives the test pins
// Notes: Each scenario task judges its own results
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_in, rst_n_in, tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic [4:0]  afs_in, pue_in, afs_out, pue_out;
  logic        cfg_wr, gpio_mode, upd, sw_en;
  logic [31:0] rdata;
  logic [2:0]  ack;
  logic [3:0]  ir;
  logic [34:0] wdata;
  logic [63:0] dout;
  int          failures, checks_done, cycles, upd_count;

  jts_probe u_probe (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
    .test_reset_n_out(trst_n), .tdo_in(tdo));

  jts_tap u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .test_reset_n_in(trst_n), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
    .alt_function_select_in(afs_in), .pull_up_enable_in(pue_in), .pad_cfg_wr_in(cfg_wr),
    .alt_function_select_out(afs_out), .pull_up_enable_out(pue_out),
    .gpio_mode_out(gpio_mode), .dap_rdata_in(rdata), .dap_ack_in(ack), .ir_out(ir),
    .dap_wdata_out(wdata), .dap_update_out(upd), .sw_enable_out(sw_en));

  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
  begin
    cycles++;
    if (upd === 1'b1)
      upd_count++;
    if (cycles == 30000)
    begin
      failures++;
      end_of_test();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic pad_write(input logic [4:0] afs, input logic [4:0] pue);
    @(posedge clk_in);
    #1;
    afs_in = afs;
    pue_in = pue;
    cfg_wr = 1'b1;
    @(posedge clk_in);
    #1;
    cfg_wr = 1'b0;
    repeat (3) @(posedge clk_in);
  endtask

  // From any state: reset, idle, shift the code, update, idle
  task automatic load_ir(input logic [3:0] code);
    u_probe.tms_walk(16'h00DF, 10);
    u_probe.scan({60'h0, code}, 4, dout);
    u_probe.tms_walk(16'h0001, 2);
  endtask

  task automatic t_reset();
    check(ir, jts_pkg::IR_IDCODE);
    check(afs_out, jts_pkg::PIN_DEFAULT);
    check(pue_out, jts_pkg::PIN_DEFAULT);
    check(gpio_mode, 1'b0);
    check(sw_en, 1'b0);
    check(tdo_oe, 1'b0);
    $display("test reset_defaults done");
  endtask

  task automatic t_idcode();
    u_probe.tms_walk(16'h0002, 4);
    u_probe.scan(64'h0, 32, dout);
    u_probe.tms_walk(16'h0001, 2);
    check(dout[31:0], jts_pkg::ID_DEFAULT);
    $display("test idcode_scan done");
  endtask

  task automatic t_dpacc();
    int n;
    load_ir(jts_pkg::IR_DPACC);
    check(dout[3:0], jts_pkg::IR_CAPTURE);
    check(ir, jts_pkg::IR_DPACC);
    @(posedge clk_in);
    #1;
    rdata = 32'hA5C3_1E69;
    ack = 3'h2;
    n = upd_count;
    u_probe.tms_walk(16'h0001, 3);
    u_probe.scan(64'h4_DEAD_BEEF, 35, dout);
    u_probe.tms_walk(16'h0001, 2);
    repeat (8) @(posedge clk_in);
    check(dout[34:0], {32'hA5C3_1E69, 3'h2});
    check(upd_count - n, 1);
    check(wdata, 35'h4_DEAD_BEEF);
    $display("test dap_access done");
  endtask

  task automatic t_tap_reset();
    u_probe.tms_walk(16'h00F9, 8);
    check(ir, jts_pkg::IR_IDCODE);
    load_ir(jts_pkg::IR_APACC);
    check(ir, jts_pkg::IR_APACC);
    u_probe.pin_reset(1'b0);
    repeat (6) @(posedge clk_in);
    check(ir, jts_pkg::IR_IDCODE);
    u_probe.pin_reset(1'b1);
    repeat (4) @(posedge clk_in);
    $display("test tap_reset done");
  endtask

  task automatic t_pads();
    pad_write(5'h00, 5'h0A);
    check(afs_out, 5'h00);
    check(pue_out, 5'h0A);
    check(gpio_mode, 1'b1);
    load_ir(jts_pkg::IR_DPACC);
    check(ir, jts_pkg::IR_IDCODE);
    pad_write(5'h1F, 5'h1F);
    check(gpio_mode, 1'b0);
    load_ir(jts_pkg::IR_BYPASS);
    check(ir, jts_pkg::IR_BYPASS);
    $display("test pad_config done");
  endtask

  task automatic t_swd();
    logic [3:0] held;
    u_probe.tms_walk(16'h001F, 5);
    u_probe.tms_walk(16'hEDB6, 16);
    check(sw_en, 1'b1);
    held = ir;
    load_ir(jts_pkg::IR_DPACC);
    check(ir, held);
    check(tdo_oe, 1'b0);
    u_probe.pin_reset(1'b0);
    repeat (6) @(posedge clk_in);
    check(sw_en, 1'b0);
    u_probe.pin_reset(1'b1);
    $display("test swd_switch done");
  endtask

  initial
  begin
    rst_n_in = 1'b0;
    cfg_wr = 1'b0;
    afs_in = 5'h1F;
    pue_in = 5'h1F;
    rdata = 32'h0;
    ack = 3'h0;
    repeat (20) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    repeat (4) @(posedge clk_in);
    t_reset();
    t_idcode();
    t_dpacc();
    t_tap_reset();
    t_pads();
    t_swd();
    end_of_test();
  end
endmodule
